// ===== logic/glc_pkg.sv
package glc_pkg;

   // ----------------------------------------
   // Bus geometry
   // ----------------------------------------
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int REG_W = 8;
   localparam int NUM_CH = 14;
   localparam int CNT_W = 16;

   // ----------------------------------------
   // Register indices (byte address = 4 * index)
   // ----------------------------------------
   localparam logic [7:0] IDX_RX_SLICER_EQ_TRIM = 8'he3;
   localparam logic [7:0] IDX_MASTER_CLOCK_OUT_RATE = 8'he4;
   localparam logic [7:0] IDX_VIOLATION_COUNTER_CONTROL = 8'he5;
   localparam logic [7:0] IDX_COUNTER_COMMAND = 8'he6;
   localparam logic [7:0] IDX_COUNTER_BYTE = 8'he8;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'hf0;
   localparam logic [7:0] IDX_IRQ_MASK = 8'hf1;
   localparam logic [1:0] WORD_LSB = 2'h0;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [REG_W-1:0] RST_REG = 8'h00;
   localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_FULL = 16'hffff;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int SLICER_LSB = 2;
   localparam int EQ_TRIM_LSB = 0;
   localparam int T1_RATE_LSB = 6;
   localparam int E1_RATE_LSB = 4;
   localparam int MON_SEL_BIT = 7;
   localparam int READBACK_EN_BIT = 6;
   localparam int CH_SEL_LSB = 0;
   localparam int CH_SEL_W = 4;
   localparam int CMD_CH_CLEAR_BIT = 0;
   localparam int CMD_CH_LATCH_BIT = 1;
   localparam int CMD_BYTE_SEL_BIT = 2;
   localparam int CMD_ALL_LATCH_BIT = 3;
   localparam int CMD_ALL_CLEAR_BIT = 4;
   localparam int IRQ_SAT_BIT = 0;
   localparam int IRQ_LATCH_BIT = 1;
   localparam int IRQ_W = 2;
   localparam logic [CH_SEL_W-1:0] CH_SEL_NONE = 4'h0;
   localparam logic [CH_SEL_W-1:0] CH_SEL_LAST = 4'he;

   // ----------------------------------------
   // Response codes
   // ----------------------------------------
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic [3:0] strb;
   } glc_wr_cmd_s;

endpackage

// ===== logic/glc_axil_slave.sv
`timescale 1ns/1ps
module glc_axil_slave
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Write address and data
   input wire logic [glc_pkg::ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [glc_pkg::DATA_W-1:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   // Write response
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // Read address and data
   input wire logic [glc_pkg::ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [glc_pkg::DATA_W-1:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Register file side
   output glc_pkg::glc_wr_cmd_s wr_cmd,
   output logic wr_req,
   input wire logic wr_hit,
   output logic [glc_pkg::ADDR_W-1:0] rd_addr,
   output logic rd_req,
   input wire logic rd_hit,
   input wire logic [glc_pkg::DATA_W-1:0] rd_data
);

   logic aw_held;
   logic w_held;
   logic ar_held;
   logic next_aw_held;
   logic next_w_held;
   logic next_ar_held;
   logic next_awready;
   logic next_wready;
   logic next_arready;
   logic next_bvalid;
   logic next_rvalid;
   logic [1:0] next_bresp;
   logic [1:0] next_rresp;
   logic [glc_pkg::DATA_W-1:0] next_rdata;
   glc_pkg::glc_wr_cmd_s next_wr_cmd;
   logic [glc_pkg::ADDR_W-1:0] next_rd_addr;

   assign wr_req = aw_held && w_held && !bvalid;
   assign rd_req = ar_held && !rvalid;

   always_comb
   begin
      next_aw_held = aw_held;
      next_w_held = w_held;
      next_ar_held = ar_held;
      next_wr_cmd = wr_cmd;
      next_rd_addr = rd_addr;
      next_bvalid = bvalid && !bready;
      next_rvalid = rvalid && !rready;
      next_bresp = bresp;
      next_rresp = rresp;
      next_rdata = rdata;
      if (awvalid && awready)
      begin
         next_aw_held = 1'b1;
         next_wr_cmd.addr = awaddr;
      end
      if (wvalid && wready)
      begin
         next_w_held = 1'b1;
         next_wr_cmd.data = wdata;
         next_wr_cmd.strb = wstrb;
      end
      if (arvalid && arready)
      begin
         next_ar_held = 1'b1;
         next_rd_addr = araddr;
      end
      if (wr_req)
      begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = wr_hit ? glc_pkg::RESP_OKAY : glc_pkg::RESP_SLVERR;
      end
      if (rd_req)
      begin
         next_ar_held = 1'b0;
         next_rvalid = 1'b1;
         next_rdata = rd_data;
         next_rresp = rd_hit ? glc_pkg::RESP_OKAY : glc_pkg::RESP_SLVERR;
      end
      next_awready = !next_aw_held;
      next_wready = !next_w_held;
      next_arready = !next_ar_held;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         ar_held <= 1'b0;
         awready <= 1'b0;
         wready <= 1'b0;
         arready <= 1'b0;
         bvalid <= 1'b0;
         rvalid <= 1'b0;
         bresp <= glc_pkg::RESP_OKAY;
         rresp <= glc_pkg::RESP_OKAY;
         rdata <= '0;
         wr_cmd <= '0;
         rd_addr <= '0;
      end
      else
      begin
         aw_held <= next_aw_held;
         w_held <= next_w_held;
         ar_held <= next_ar_held;
         awready <= next_awready;
         wready <= next_wready;
         arready <= next_arready;
         bvalid <= next_bvalid;
         rvalid <= next_rvalid;
         bresp <= next_bresp;
         rresp <= next_rresp;
         rdata <= next_rdata;
         wr_cmd <= next_wr_cmd;
         rd_addr <= next_rd_addr;
      end
   end

endmodule

// ===== logic/glc_violation_counter.sv
`timescale 1ns/1ps
module glc_violation_counter
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Events and commands
   input wire logic violation,
   input wire logic clear,
   input wire logic latch,
   // State
   output logic [glc_pkg::CNT_W-1:0] held_count,
   output logic saturated
);

   logic [glc_pkg::CNT_W-1:0] count;
   logic [glc_pkg::CNT_W-1:0] next_count;
   logic [glc_pkg::CNT_W-1:0] next_held_count;

   assign saturated = (count == glc_pkg::CNT_FULL);

   always_comb
   begin
      next_count = count;
      next_held_count = held_count;
      if (clear)
      begin
         next_count = glc_pkg::CNT_ZERO;
      end
      else if (violation && !saturated)
      begin
         next_count = count + 16'h0001;
      end
      if (latch)
      begin
         next_held_count = count;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         count <= glc_pkg::CNT_ZERO;
         held_count <= glc_pkg::CNT_ZERO;
      end
      else
      begin
         count <= next_count;
         held_count <= next_held_count;
      end
   end

endmodule

// ===== logic/glc_global_regs.sv
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
module glc_global_regs
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write
   input wire logic [glc_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [glc_pkg::DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [glc_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [glc_pkg::DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Line side
   input wire logic [glc_pkg::NUM_CH-1:0] line_code_violation,
   output logic [glc_pkg::NUM_CH-1:0] violation_monitor,
   // Analog and clock synthesizer controls
   output logic [1:0] slicer_level,
   output logic [1:0] eq_gain_trim,
   output logic [1:0] t1_master_clock_rate,
   output logic [1:0] e1_master_clock_rate,
   // Interrupt
   output logic irq
);

   // ----------------------------------------
   // Bus slave
   // ----------------------------------------
   glc_pkg::glc_wr_cmd_s wr_cmd;
   logic wr_req;
   logic wr_hit;
   logic [glc_pkg::ADDR_W-1:0] rd_addr;
   logic rd_req;
   logic rd_hit;
   logic [glc_pkg::DATA_W-1:0] rd_data;

   glc_axil_slave u_slave
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .awaddr(s_axi_awaddr),
      .awvalid(s_axi_awvalid),
      .awready(s_axi_awready),
      .wdata(s_axi_wdata),
      .wstrb(s_axi_wstrb),
      .wvalid(s_axi_wvalid),
      .wready(s_axi_wready),
      .bresp(s_axi_bresp),
      .bvalid(s_axi_bvalid),
      .bready(s_axi_bready),
      .araddr(s_axi_araddr),
      .arvalid(s_axi_arvalid),
      .arready(s_axi_arready),
      .rdata(s_axi_rdata),
      .rresp(s_axi_rresp),
      .rvalid(s_axi_rvalid),
      .rready(s_axi_rready),
      .wr_cmd(wr_cmd),
      .wr_req(wr_req),
      .wr_hit(wr_hit),
      .rd_addr(rd_addr),
      .rd_req(rd_req),
      .rd_hit(rd_hit),
      .rd_data(rd_data)
   );

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   function automatic logic [glc_pkg::ADDR_W-1:0] byte_addr(input logic [7:0] idx);
      byte_addr = {2'h0, idx, glc_pkg::WORD_LSB};
   endfunction

   function automatic logic known(input logic [glc_pkg::ADDR_W-1:0] a);
      known = (a == byte_addr(glc_pkg::IDX_RX_SLICER_EQ_TRIM))
         || (a == byte_addr(glc_pkg::IDX_MASTER_CLOCK_OUT_RATE))
         || (a == byte_addr(glc_pkg::IDX_VIOLATION_COUNTER_CONTROL))
         || (a == byte_addr(glc_pkg::IDX_COUNTER_COMMAND))
         || (a == byte_addr(glc_pkg::IDX_COUNTER_BYTE))
         || (a == byte_addr(glc_pkg::IDX_IRQ_STATUS))
         || (a == byte_addr(glc_pkg::IDX_IRQ_MASK));
   endfunction

   assign wr_hit = known(wr_cmd.addr);
   assign rd_hit = known(rd_addr);

   // ----------------------------------------
   // Register storage
   // ----------------------------------------
   logic [glc_pkg::REG_W-1:0] rx_slicer_eq_trim;
   logic [glc_pkg::REG_W-1:0] master_clock_out_rate;
   logic [glc_pkg::REG_W-1:0] violation_counter_control;
   logic [glc_pkg::REG_W-1:0] counter_command;
   logic [glc_pkg::IRQ_W-1:0] irq_status;
   logic [glc_pkg::IRQ_W-1:0] irq_mask;
   logic [glc_pkg::REG_W-1:0] next_rx_slicer_eq_trim;
   logic [glc_pkg::REG_W-1:0] next_master_clock_out_rate;
   logic [glc_pkg::REG_W-1:0] next_violation_counter_control;
   logic [glc_pkg::REG_W-1:0] next_counter_command;
   logic [glc_pkg::IRQ_W-1:0] next_irq_status;
   logic [glc_pkg::IRQ_W-1:0] next_irq_mask;
   logic wr_lane0;

   assign wr_lane0 = wr_req && wr_cmd.strb[0];

   // ----------------------------------------
   // Counter command decode
   // ----------------------------------------
   logic [glc_pkg::CH_SEL_W-1:0] channel_select;
   logic channel_counter_clear;
   logic all_counters_clear;
   logic channel_counter_latch;
   logic all_counters_latch;
   logic count_byte_select;
   logic latch_prev;
   logic latch_rise;
   logic [glc_pkg::NUM_CH-1:0] ch_clear;
   logic [glc_pkg::NUM_CH-1:0] ch_latch;
   logic [glc_pkg::NUM_CH-1:0] ch_sat;
   logic [glc_pkg::CNT_W-1:0] held [glc_pkg::NUM_CH];
   logic [glc_pkg::NUM_CH-1:0] sat_prev;

   assign channel_select =
      violation_counter_control[glc_pkg::CH_SEL_LSB +: glc_pkg::CH_SEL_W];
   assign channel_counter_clear = counter_command[glc_pkg::CMD_CH_CLEAR_BIT];
   assign all_counters_clear = counter_command[glc_pkg::CMD_ALL_CLEAR_BIT];
   assign channel_counter_latch = counter_command[glc_pkg::CMD_CH_LATCH_BIT];
   assign all_counters_latch = counter_command[glc_pkg::CMD_ALL_LATCH_BIT];
   assign count_byte_select = counter_command[glc_pkg::CMD_BYTE_SEL_BIT];
   // Latch once when the latch bits go from none set to any set, not every cycle one stays set
   assign latch_rise = (channel_counter_latch || all_counters_latch) && !latch_prev;

   for (genvar ch = 0; ch < glc_pkg::NUM_CH; ch++)
   begin : g_ch
      logic picked;
      assign picked = (channel_select == glc_pkg::CH_SEL_W'(ch + 1));
      // Clear follows the held bit for as long as the host keeps it
      assign ch_clear[ch] = all_counters_clear || (channel_counter_clear && picked);
      assign ch_latch[ch] = latch_rise && (all_counters_latch || picked);
      glc_violation_counter u_cnt
      (
         .aclk(aclk),
         .aresetn(aresetn),
         .violation(line_code_violation[ch]),
         .clear(ch_clear[ch]),
         .latch(ch_latch[ch]),
         .held_count(held[ch]),
         .saturated(ch_sat[ch])
      );
   end

   // ----------------------------------------
   // Read mux
   // ----------------------------------------
   logic [glc_pkg::REG_W-1:0] counter_byte_value;

   always_comb
   begin
      counter_byte_value = glc_pkg::RST_REG;
      if (violation_counter_control[glc_pkg::READBACK_EN_BIT]
         && channel_select != glc_pkg::CH_SEL_NONE
         && channel_select <= glc_pkg::CH_SEL_LAST)
      begin
         counter_byte_value = count_byte_select
            ? held[channel_select - 4'h1][glc_pkg::CNT_W-1:glc_pkg::REG_W]
            : held[channel_select - 4'h1][glc_pkg::REG_W-1:0];
      end
   end

   always_comb
   begin
      rd_data = '0;
      if (rd_addr == byte_addr(glc_pkg::IDX_RX_SLICER_EQ_TRIM))
         rd_data[glc_pkg::REG_W-1:0] = rx_slicer_eq_trim;
      else if (rd_addr == byte_addr(glc_pkg::IDX_MASTER_CLOCK_OUT_RATE))
         rd_data[glc_pkg::REG_W-1:0] = master_clock_out_rate;
      else if (rd_addr == byte_addr(glc_pkg::IDX_VIOLATION_COUNTER_CONTROL))
         rd_data[glc_pkg::REG_W-1:0] = violation_counter_control;
      else if (rd_addr == byte_addr(glc_pkg::IDX_COUNTER_COMMAND))
         rd_data[glc_pkg::REG_W-1:0] = counter_command;
      else if (rd_addr == byte_addr(glc_pkg::IDX_COUNTER_BYTE))
         rd_data[glc_pkg::REG_W-1:0] = counter_byte_value;
      else if (rd_addr == byte_addr(glc_pkg::IDX_IRQ_STATUS))
         rd_data[glc_pkg::IRQ_W-1:0] = irq_status;
      else if (rd_addr == byte_addr(glc_pkg::IDX_IRQ_MASK))
         rd_data[glc_pkg::IRQ_W-1:0] = irq_mask;
   end

   // ----------------------------------------
   // Register update
   // ----------------------------------------
   logic [glc_pkg::IRQ_W-1:0] events;
   logic [glc_pkg::NUM_CH-1:0] next_monitor;
   logic [1:0] next_slicer_level;
   logic [1:0] next_eq_gain_trim;
   logic [1:0] next_t1_master_clock_rate;
   logic [1:0] next_e1_master_clock_rate;
   logic next_irq;
   logic next_latch_prev;

   always_comb
   begin
      next_rx_slicer_eq_trim = rx_slicer_eq_trim;
      next_master_clock_out_rate = master_clock_out_rate;
      next_violation_counter_control = violation_counter_control;
      next_counter_command = counter_command;
      next_irq_mask = irq_mask;
      // Unused bits of the 8-bit registers are stored whole; irq_mask keeps only its IRQ_W bits
      if (wr_lane0 && wr_cmd.addr == byte_addr(glc_pkg::IDX_RX_SLICER_EQ_TRIM))
         next_rx_slicer_eq_trim = wr_cmd.data[glc_pkg::REG_W-1:0];
      if (wr_lane0 && wr_cmd.addr == byte_addr(glc_pkg::IDX_MASTER_CLOCK_OUT_RATE))
         next_master_clock_out_rate = wr_cmd.data[glc_pkg::REG_W-1:0];
      if (wr_lane0 && wr_cmd.addr == byte_addr(glc_pkg::IDX_VIOLATION_COUNTER_CONTROL))
         next_violation_counter_control = wr_cmd.data[glc_pkg::REG_W-1:0];
      if (wr_lane0 && wr_cmd.addr == byte_addr(glc_pkg::IDX_COUNTER_COMMAND))
         next_counter_command = wr_cmd.data[glc_pkg::REG_W-1:0];
      if (wr_lane0 && wr_cmd.addr == byte_addr(glc_pkg::IDX_IRQ_MASK))
         next_irq_mask = wr_cmd.data[glc_pkg::IRQ_W-1:0];
      events = '0;
      events[glc_pkg::IRQ_SAT_BIT] = |(ch_sat & ~sat_prev);
      events[glc_pkg::IRQ_LATCH_BIT] = |ch_latch;
      // Read clears, a new event in the same cycle survives
      next_irq_status = irq_status | events;
      if (rd_req && rd_addr == byte_addr(glc_pkg::IDX_IRQ_STATUS))
         next_irq_status = events;
      // Monitor shows activity or saturation per channel
      next_monitor = violation_counter_control[glc_pkg::MON_SEL_BIT]
         ? ch_sat : line_code_violation;
      // Pin-side controls follow the register image of this edge
      next_slicer_level = next_rx_slicer_eq_trim[glc_pkg::SLICER_LSB +: 2];
      next_eq_gain_trim = next_rx_slicer_eq_trim[glc_pkg::EQ_TRIM_LSB +: 2];
      next_t1_master_clock_rate = next_master_clock_out_rate[glc_pkg::T1_RATE_LSB +: 2];
      next_e1_master_clock_rate = next_master_clock_out_rate[glc_pkg::E1_RATE_LSB +: 2];
      // Interrupt level matches status as it will stand
      next_irq = |(next_irq_status & next_irq_mask);
      next_latch_prev = channel_counter_latch || all_counters_latch;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rx_slicer_eq_trim <= glc_pkg::RST_REG;
         master_clock_out_rate <= glc_pkg::RST_REG;
         violation_counter_control <= glc_pkg::RST_REG;
         counter_command <= glc_pkg::RST_REG;
         irq_status <= '0;
         irq_mask <= '0;
         latch_prev <= 1'b0;
         sat_prev <= '0;
         violation_monitor <= '0;
         slicer_level <= '0;
         eq_gain_trim <= '0;
         t1_master_clock_rate <= '0;
         e1_master_clock_rate <= '0;
         irq <= 1'b0;
      end
      else
      begin
         rx_slicer_eq_trim <= next_rx_slicer_eq_trim;
         master_clock_out_rate <= next_master_clock_out_rate;
         violation_counter_control <= next_violation_counter_control;
         counter_command <= next_counter_command;
         irq_status <= next_irq_status;
         irq_mask <= next_irq_mask;
         latch_prev <= next_latch_prev;
         sat_prev <= ch_sat;
         violation_monitor <= next_monitor;
         slicer_level <= next_slicer_level;
         eq_gain_trim <= next_eq_gain_trim;
         t1_master_clock_rate <= next_t1_master_clock_rate;
         e1_master_clock_rate <= next_e1_master_clock_rate;
         irq <= next_irq;
      end
   end

endmodule

// ===== verif/glc_global_regs_assertions.sv
`timescale 1ns/1ps
module glc_global_regs_assertions
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Bus handshakes
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [glc_pkg::DATA_W-1:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Controls
   input wire logic [1:0] slicer_level,
   input wire logic [1:0] eq_gain_trim,
   input wire logic [1:0] t1_master_clock_rate,
   input wire logic [1:0] e1_master_clock_rate,
   input wire logic irq
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   property p_wr_answer;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid;
   endproperty
   a_wr_answer: assert property (p_wr_answer) else $error("write unanswered");
   property p_rd_answer;
      s_axi_arvalid && s_axi_arready |=> !s_axi_arready ##1 s_axi_rvalid;
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read unanswered");
   property p_b_stands;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_stands: assert property (p_b_stands) else $error("bresp dropped");
   property p_r_stands;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_stands: assert property (p_r_stands) else $error("rdata dropped");
   property p_aw_drop;
      s_axi_awvalid && s_axi_awready |=> !s_axi_awready ##1 s_axi_bvalid;
   endproperty
   a_aw_drop: assert property (p_aw_drop) else $error("awready stayed");
   property p_ready_back;
      s_axi_bvalid && s_axi_bready |=> s_axi_awready && s_axi_wready;
   endproperty
   a_ready_back: assert property (p_ready_back) else $error("no ready");
   property p_upper_zero;
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("upper bits set");
   property p_ctrl_hold;
      $past(aresetn) && !$rose(s_axi_bvalid) |->
         $stable({slicer_level, eq_gain_trim, t1_master_clock_rate, e1_master_clock_rate});
   endproperty
   a_ctrl_hold: assert property (p_ctrl_hold) else $error("control moved");

   c_wr: cover property (s_axi_bvalid && s_axi_bready);
   c_rd: cover property (s_axi_rvalid && s_axi_rready);
   c_irq: cover property ($rose(irq));
endmodule

bind glc_global_regs glc_global_regs_assertions chk_i
(
   .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .slicer_level, .eq_gain_trim,
   .t1_master_clock_rate, .e1_master_clock_rate, .irq
);

// ===== verif/glc_global_regs_tb.sv
`timescale 1ns/1ps
module glc_global_regs_tb;
   localparam logic [11:0] A_TRIM = {2'h0, glc_pkg::IDX_RX_SLICER_EQ_TRIM, 2'h0};
   localparam logic [11:0] A_RATE = {2'h0, glc_pkg::IDX_MASTER_CLOCK_OUT_RATE, 2'h0};
   localparam logic [11:0] A_CTRL = {2'h0, glc_pkg::IDX_VIOLATION_COUNTER_CONTROL, 2'h0};
   localparam logic [11:0] A_CMD = {2'h0, glc_pkg::IDX_COUNTER_COMMAND, 2'h0};
   localparam logic [11:0] A_BYTE = {2'h0, glc_pkg::IDX_COUNTER_BYTE, 2'h0};
   localparam logic [11:0] A_STAT = {2'h0, glc_pkg::IDX_IRQ_STATUS, 2'h0};
   localparam logic [11:0] A_MASK = {2'h0, glc_pkg::IDX_IRQ_MASK, 2'h0};

   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic [13:0] line_code_violation = 14'h0, violation_monitor;
   logic [1:0] slicer_level, eq_gain_trim, t1_master_clock_rate, e1_master_clock_rate;
   int miscompares = 0;
   int n_compared = 0;

   glc_global_regs uut
   (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .line_code_violation,
      .violation_monitor, .slicer_level, .eq_gain_trim, .t1_master_clock_rate,
      .e1_master_clock_rate, .irq
   );

   initial
   begin
      forever #50 aclk = ~aclk;
   end

   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         miscompares++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // ----------------------------------------
   // Bus cycles
   // ----------------------------------------
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      resp = s_axi_bresp;
      @(posedge aclk);
   endtask

   task automatic rd(input logic [11:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      rv = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge aclk);
   endtask

   task automatic rchk(input logic [11:0] a, input logic [31:0] e);
      rd(a);
      chk(rv, e);
      chk(32'(resp), 32'(glc_pkg::RESP_OKAY));
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_regs();
      logic [7:0] v;
      for (int i = 0; i < 4; i++)
      begin
         v = {2'(i), 2'(3 - i), 2'(i), 2'(3 - i)};
         wr(A_TRIM, v);
         wr(A_RATE, v);
         chk(32'(slicer_level), 32'(i));
         chk(32'(eq_gain_trim), 32'(3 - i));
         chk(32'(t1_master_clock_rate), 32'(i));
         chk(32'(e1_master_clock_rate), 32'(3 - i));
         rchk(A_TRIM, 32'(v));
         rchk(A_RATE, 32'(v));
      end
      s_axi_wstrb <= 4'he;
      wr(A_TRIM, 8'h55);
      s_axi_wstrb <= 4'hf;
      chk(32'(resp), 32'(glc_pkg::RESP_OKAY));
      rchk(A_TRIM, 32'(v));
      wr(12'h3d0, 8'h55);
      chk(32'(resp), 32'(glc_pkg::RESP_SLVERR));
      rd(12'h3d0);
      chk({rv[31:2], resp}, 32'(glc_pkg::RESP_SLVERR));
   endtask

   task automatic t_count();
      wr(A_CTRL, 8'h4e);
      line_code_violation <= 14'h2001;
      repeat (5) @(posedge aclk);
      line_code_violation <= 14'h2000;
      #1 chk(32'(violation_monitor), 32'h2001);
      @(posedge aclk);
      repeat (294) @(posedge aclk);
      line_code_violation <= 14'h0;
      wr(A_CMD, 8'h02);
      wr(A_CMD, 8'h00);
      rchk(A_BYTE, 32'h2c);
      wr(A_CMD, 8'h04);
      rchk(A_BYTE, 32'h01);
      wr(A_CTRL, 8'h41);
      rchk(A_BYTE, 32'h00);
      wr(A_CMD, 8'h08);
      wr(A_CMD, 8'h00);
      rchk(A_BYTE, 32'h05);
      wr(A_CTRL, 8'h01);
      rchk(A_BYTE, 32'h00);
      wr(A_CTRL, 8'h40);
      rchk(A_BYTE, 32'h00);
      chk(32'(irq), 32'h0);
   endtask

   task automatic t_sat();
      wr(A_CTRL, 8'hce);
      wr(A_MASK, 8'h01);
      line_code_violation <= 14'h2000;
      repeat (65300) @(posedge aclk);
      line_code_violation <= 14'h0;
      @(posedge aclk);
      chk(32'(violation_monitor), 32'h2000);
      chk(32'(irq), 32'h1);
      wr(A_CMD, 8'h06);
      wr(A_CMD, 8'h04);
      rchk(A_BYTE, 32'hff);
      wr(A_CMD, 8'h00);
      rchk(A_BYTE, 32'hff);
      rchk(A_STAT, 32'h3);
      rchk(A_STAT, 32'h0);
      chk(32'(irq), 32'h0);
      wr(A_CMD, 8'h01);
      repeat (10) @(posedge aclk);
      wr(A_CMD, 8'h02);
      wr(A_CMD, 8'h00);
      rchk(A_BYTE, 32'h00);
      chk(32'(violation_monitor), 32'h0);
   endtask

   initial
   begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      rchk(A_TRIM, 32'h0);
      rchk(A_RATE, 32'h0);
      rchk(A_CTRL, 32'h0);
      t_regs();
      t_count();
      t_sat();
      print_verdict();
   end

   initial
   begin
      repeat (80000) @(posedge aclk);
      miscompares++;
      print_verdict();
   end
endmodule
